// [design/sadc_ctrl.sv]
// successive-approximation converter control with register port and interrupt
module sadc_ctrl #(
    parameter int MC_CLKS = sadc_pkg::MC_CLKS_DEFAULT
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // register port
    input wire sadc_pkg::sadc_bus_s i_bus,
    output logic [sadc_pkg::DATA_W-1:0] o_rdata,
    // interrupt
    output logic o_irq,
    // external start pin
    input wire logic i_external_start_pin,
    // analog side
    input wire logic i_cmp_above,
    output sadc_pkg::sadc_ana_s o_ana
);

    // register hit on a given offset
    function automatic logic reg_hit(input logic [sadc_pkg::ADDR_W-1:0] addr,
                                     input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    logic mc_end;
    sadc_pkg::sadc_state_e state;
    logic converter_enable;
    logic external_start_enable;
    logic [sadc_pkg::CHAN_W-1:0] chan_sel;
    logic start_cmd;
    logic busy_flag;
    logic pin_prev;
    logic ext_edge;
    logic [2:0] sample_cnt;
    logic [1:0] step_cnt;
    logic [3:0] bit_idx;
    logic [sadc_pkg::RES_W-1:0] sar;
    logic [sadc_pkg::RES_W-1:0] result;
    logic [sadc_pkg::IRQ_W-1:0] irq_status;
    logic [sadc_pkg::IRQ_W-1:0] irq_mask;
    logic conv_done;
    logic go;
    logic wr_ctrl;
    logic rd_status;
    logic [sadc_pkg::DATA_W-1:0] next_rdata;

    sadc_mc_timer #(
        .MC_CLKS(MC_CLKS)
    ) u_timer (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .o_mc_end(mc_end)
    );

    // write and read decode
    assign wr_ctrl = i_bus.wr && reg_hit(i_bus.addr, sadc_pkg::OFF_CTRL);
    assign rd_status = i_bus.rd && reg_hit(i_bus.addr, sadc_pkg::OFF_STATUS);

    // enable bit always writable; the rest only while enabled
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            converter_enable <= 1'b0;
        end else if (wr_ctrl) begin
            converter_enable <= i_bus.wdata[sadc_pkg::CTRL_ENABLE_BIT];
        end
    end

    // mode and channel fields; ignored while disabled
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !converter_enable) begin
            external_start_enable <= 1'b0;
            chan_sel <= sadc_pkg::CHAN_RESET;
        end else if (wr_ctrl) begin
            external_start_enable <= i_bus.wdata[sadc_pkg::CTRL_EXT_EN_BIT];
            chan_sel <= i_bus.wdata[sadc_pkg::CTRL_CHAN_LSB +: sadc_pkg::CHAN_W];
        end
    end

    // pin sampled once per machine cycle, edge judged at cycle end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_prev <= 1'b1;
        end else if (mc_end) begin
            pin_prev <= i_external_start_pin;
        end
    end

    // a level held less than a machine cycle may be missed, by design
    assign ext_edge = mc_end && !pin_prev && i_external_start_pin;

    // command flop: set by a write of one, consumed when the sequence begins
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !converter_enable) begin
            start_cmd <= 1'b0;
        end else if (wr_ctrl && i_bus.wdata[sadc_pkg::CTRL_START_BIT]
                     && i_bus.wdata[sadc_pkg::CTRL_ENABLE_BIT]
                     && state == sadc_pkg::ST_IDLE) begin
            start_cmd <= 1'b1;
        end else if (go) begin
            start_cmd <= 1'b0;
        end
    end

    // start taken at machine cycle end, sequence runs from the next cycle
    assign go = (state == sadc_pkg::ST_IDLE) && mc_end && converter_enable
                && (start_cmd || (external_start_enable && ext_edge));

    // conversion sequencer, advancing only on machine cycle ends
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !converter_enable) begin
            state <= sadc_pkg::ST_IDLE;
        end else begin
            case (state)
                sadc_pkg::ST_IDLE: begin
                    if (go) begin
                        state <= sadc_pkg::ST_INIT_A;
                    end
                end
                sadc_pkg::ST_INIT_A: begin
                    if (mc_end) begin
                        state <= sadc_pkg::ST_INIT_B;
                    end
                end
                sadc_pkg::ST_INIT_B: begin
                    if (mc_end) begin
                        state <= sadc_pkg::ST_SAMPLE;
                    end
                end
                sadc_pkg::ST_SAMPLE: begin
                    if (mc_end && sample_cnt == sadc_pkg::SAMPLE_LAST) begin
                        state <= sadc_pkg::ST_CONVERT;
                    end
                end
                sadc_pkg::ST_CONVERT: begin
                    if (conv_done) begin
                        state <= sadc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sadc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // eight machine cycle sampling window counter
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || state != sadc_pkg::ST_SAMPLE) begin
            sample_cnt <= '0;
        end else if (mc_end) begin
            sample_cnt <= sample_cnt + 1'b1;
        end
    end

    // four machine cycles per bit; decision on the last cycle end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || state != sadc_pkg::ST_CONVERT) begin
            step_cnt <= '0;
        end else if (mc_end) begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    assign conv_done = (state == sadc_pkg::ST_CONVERT) && mc_end
                       && step_cnt == sadc_pkg::BIT_LAST
                       && bit_idx == sadc_pkg::LSB_INDEX;

    // bit under trial: top bit first, then each lower bit
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || state != sadc_pkg::ST_CONVERT) begin
            bit_idx <= sadc_pkg::MSB_INDEX;
        end else if (mc_end && step_cnt == sadc_pkg::BIT_LAST
                     && bit_idx != sadc_pkg::LSB_INDEX) begin
            bit_idx <= bit_idx - 1'b1;
        end
    end

    // approximation register: trial bit set, kept only if input is above
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sar <= sadc_pkg::RESULT_RESET;
        end else if (state == sadc_pkg::ST_SAMPLE && mc_end
                     && sample_cnt == sadc_pkg::SAMPLE_LAST) begin
            sar <= sadc_pkg::HALF_SCALE;
        end else if (state == sadc_pkg::ST_CONVERT && mc_end
                     && step_cnt == sadc_pkg::BIT_LAST) begin
            sar[bit_idx] <= i_cmp_above;
            if (bit_idx != sadc_pkg::LSB_INDEX) begin
                sar[bit_idx - 1'b1] <= 1'b1;
            end
        end
    end

    // busy status flag: set after first init cycle, cleared on finish
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !converter_enable) begin
            busy_flag <= 1'b0;
        end else if (state == sadc_pkg::ST_INIT_A && mc_end) begin
            busy_flag <= 1'b1;
        end else if (conv_done) begin
            busy_flag <= 1'b0;
        end
    end

    // result held for software until the next conversion ends
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            result <= sadc_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result <= {sar[sadc_pkg::RES_W-1:1], i_cmp_above};
        end
    end

    // analog drive: dac code follows sar, channel latched at start
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_ana <= '0;
        end else begin
            o_ana.dac_code <= sar;
            o_ana.sample <= (state == sadc_pkg::ST_SAMPLE);
            if (go) begin
                o_ana.channel <= chan_sel;
            end
        end
    end

    // sticky done flag; a new event wins over the read that clears it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !converter_enable) begin
            irq_status <= sadc_pkg::IRQ_RESET;
        end else if (conv_done) begin
            irq_status[sadc_pkg::STAT_DONE_BIT] <= 1'b1;
        end else if (rd_status) begin
            irq_status <= sadc_pkg::IRQ_RESET;
        end
    end

    // interrupt mask
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            irq_mask <= sadc_pkg::IRQ_RESET;
        end else if (i_bus.wr && reg_hit(i_bus.addr, sadc_pkg::OFF_MASK)) begin
            irq_mask <= i_bus.wdata[sadc_pkg::IRQ_W-1:0];
        end
    end

    // level interrupt, registered one clock behind the flag
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // read mux; control, status and result bits read as zero while disabled, the mask keeps its value
    always_comb begin
        next_rdata = '0;
        if (i_bus.rd) begin
            if (reg_hit(i_bus.addr, sadc_pkg::OFF_CTRL)) begin
                next_rdata[sadc_pkg::CTRL_ENABLE_BIT] = converter_enable;
                next_rdata[sadc_pkg::CTRL_START_BIT] = busy_flag;
                next_rdata[sadc_pkg::CTRL_EXT_EN_BIT] = external_start_enable;
                next_rdata[sadc_pkg::CTRL_CHAN_LSB +: sadc_pkg::CHAN_W] = chan_sel;
                next_rdata[sadc_pkg::CTRL_BUSY_BIT] = busy_flag;
            end else if (reg_hit(i_bus.addr, sadc_pkg::OFF_STATUS)) begin
                next_rdata[sadc_pkg::IRQ_W-1:0] = irq_status;
            end else if (reg_hit(i_bus.addr, sadc_pkg::OFF_MASK)) begin
                next_rdata[sadc_pkg::IRQ_W-1:0] = irq_mask;
            end else if (reg_hit(i_bus.addr, sadc_pkg::OFF_RESULT)
                         && converter_enable) begin
                next_rdata[sadc_pkg::RES_W-1:0] = result;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end
endmodule

// [design/sadc_pkg.sv]
// shared constants and carrier types of the successive-approximation converter control
package sadc_pkg;

    // register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0C;

    // control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_EXT_EN_BIT = 1;
    localparam int CTRL_ENABLE_BIT = 2;
    localparam int CTRL_CHAN_LSB = 4;
    localparam int CTRL_BUSY_BIT = 8;

    // status and mask fields: one event so far
    localparam int STAT_DONE_BIT = 0;
    localparam int IRQ_W = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;

    // converter geometry
    localparam int RES_W = 10;
    localparam int CHAN_W = 3;
    localparam logic [RES_W-1:0] HALF_SCALE = 10'h200;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    // sequence timing in machine cycles
    localparam int SAMPLE_MC = 8;
    localparam int BIT_MC = 4;
    localparam logic [2:0] SAMPLE_LAST = 3'h7;
    localparam logic [1:0] BIT_LAST = 2'h3;
    localparam logic [3:0] MSB_INDEX = 4'h9;
    localparam logic [3:0] LSB_INDEX = 4'h0;

    // default length of one machine cycle in core clocks
    localparam int MC_CLKS_DEFAULT = 12;

    // conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INIT_A,
        ST_INIT_B,
        ST_SAMPLE,
        ST_CONVERT
    } sadc_state_e;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sadc_bus_s;

    // analog front-end drive
    typedef struct packed {
        logic [RES_W-1:0] dac_code;
        logic sample;
        logic [CHAN_W-1:0] channel;
    } sadc_ana_s;

endpackage

// [design/sadc_mc_timer.sv]
// machine-cycle timer: one-clock tick on the last clock of each machine cycle
module sadc_mc_timer #(
    parameter int MC_CLKS = sadc_pkg::MC_CLKS_DEFAULT
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // tick out
    output logic o_mc_end
);
    localparam int CW = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
    localparam logic [CW-1:0] LAST = CW'(MC_CLKS - 1);

    logic [CW-1:0] cnt;

    // free-running divider so machine cycles keep a fixed phase to the core
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // tick registered so it lines up with the clock that ends the cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_mc_end <= 1'b0;
        end else begin
            o_mc_end <= (cnt == LAST - 1'b1) || (MC_CLKS == 1);
        end
    end
endmodule

// [verification/sadc_ctrl_asserts.sv]
// port checker for the converter control
module sadc_ctrl_chk #(
    parameter int MC_CLKS = 12
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // register port and interrupt
    input wire sadc_pkg::sadc_bus_s i_bus,
    input wire logic [sadc_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_irq,
    // start pin and analog side
    input wire logic i_external_start_pin,
    input wire logic i_cmp_above,
    input wire sadc_pkg::sadc_ana_s o_ana
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CLKS = sadc_pkg::BIT_MC * MC_CLKS;
    localparam int SAMP_CLKS = sadc_pkg::SAMPLE_MC * MC_CLKS;
    localparam logic [9:0] HALF = sadc_pkg::HALF_SCALE;
    logic [7:0] samp_cnt;
    logic [7:0] gap;
    logic [9:0] dac_q;

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // length of the current sampling window in clocks
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            samp_cnt <= 8'h00;
        end else begin
            samp_cnt <= o_ana.sample ? samp_cnt + 8'h01 : 8'h00;
        end
    end

    // clocks since the dac code last moved; saturates so idle time never wraps
    always_ff @(posedge i_core_clk) begin
        dac_q <= o_ana.dac_code;
        if (i_sys_rst) begin
            gap <= 8'hFF;
        end else if (o_ana.dac_code != dac_q) begin
            gap <= 8'h01;
        end else if (gap != 8'hFF) begin
            gap <= gap + 8'h01;
        end
    end

    // steps of the sequence
    sequence s_ctrl_read;
        i_bus.rd && i_bus.addr == sadc_pkg::OFF_CTRL;
    endsequence
    sequence s_sample_end;
        $fell(o_ana.sample);
    endsequence
    sequence s_msb_step;
        $changed(o_ana.dac_code) && $past(o_ana.dac_code) == HALF;
    endsequence

    a_rdata_quiet: assert property (!i_bus.rd |=> o_rdata == '0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (i_bus.rd && !(i_bus.addr inside
        {8'h00, 8'h04, 8'h08, 8'h0C}) |=> o_rdata == '0)
        else $error("unmapped read not zero");
    a_busy_readback: assert property (s_ctrl_read ##0 o_ana.sample |=>
        o_rdata[sadc_pkg::CTRL_BUSY_BIT] && o_rdata[sadc_pkg::CTRL_START_BIT])
        else $error("busy not read back during sampling");
    a_chan_stable: assert property (o_ana.sample |-> $stable(o_ana.channel))
        else $error("channel moved while sampling");
    a_sample_len: assert property (s_sample_end |-> samp_cnt == 8'(SAMP_CLKS))
        else $error("sampling window length wrong");
    a_half_scale: assert property (s_sample_end |-> ##[0:1] o_ana.dac_code == HALF)
        else $error("half scale not loaded after sampling");
    a_bit_spacing: assert property ($changed(o_ana.dac_code) && o_ana.dac_code != HALF
        && $past(o_ana.dac_code) != HALF |-> gap == 8'(BIT_CLKS))
        else $error("bit step spacing wrong");
    a_msb_decide: assert property (s_msb_step |-> o_ana.dac_code[8]
        && o_ana.dac_code[9] == $past(i_cmp_above, 2))
        else $error("top bit decision wrong");
    a_irq_clear: assert property ($fell(o_irq) |-> $past(i_bus.rd || i_bus.wr, 2))
        else $error("interrupt dropped without an access");
endmodule

bind sadc_ctrl sadc_ctrl_chk #(.MC_CLKS(MC_CLKS)) u_chk (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .o_irq(o_irq),
    .i_external_start_pin(i_external_start_pin),
    .i_cmp_above(i_cmp_above),
    .o_ana(o_ana)
);

// [verification/sadc_front.sv]
// far-side model: analog source with comparator and start trigger
module sadc_front (
    // clock and analog levels
    input wire logic i_core_clk,
    input wire logic [9:0] i_vin,
    input wire logic [9:0] i_dac_code,
    // toward the converter
    output logic o_cmp_above,
    output logic o_start_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ideal comparator, strictly above the dac level
    assign o_cmp_above = i_vin > i_dac_code;

    // pin idles high; a pulse holds low then high for whole clocks
    initial o_start_pin = 1'b1;
    task automatic pulse(input int low_clks, input int high_clks);
        @(posedge i_core_clk);
        o_start_pin <= 1'b0;
        repeat (low_clks) @(posedge i_core_clk);
        o_start_pin <= 1'b1;
        repeat (high_clks) @(posedge i_core_clk);
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the converter control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC = 3;
    localparam int LIMIT = 30000;
    typedef struct {
        string nm;
        logic [31:0] exp;
        logic [31:0] msk;
    } sadc_note_s;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    sadc_pkg::sadc_bus_s bus = '0;
    logic [31:0] rdata;
    logic irq;
    logic pin;
    logic cmp;
    sadc_pkg::sadc_ana_s ana;
    logic [9:0] vin = 10'h000;
    sadc_note_s notes[$];
    sadc_note_s note;
    logic rd_seen = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #25 i_core_clk = ~i_core_clk;

    sadc_ctrl #(.MC_CLKS(MC)) DUT (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
        .o_irq(irq), .i_external_start_pin(pin), .i_cmp_above(cmp), .o_ana(ana)
    );
    sadc_front u_front (
        .i_core_clk(i_core_clk), .i_vin(vin), .i_dac_code(ana.dac_code),
        .o_cmp_above(cmp), .o_start_pin(pin)
    );

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] got);
        n_tests++;
        if (got !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask

    // read data land one clock after the strobe; pair with the oldest note
    always @(posedge i_core_clk) begin
        if (rd_seen) begin
            note = notes.pop_front();
            check(note.nm, note.exp, rdata & note.msk);
        end
        rd_seen <= bus.rd;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, input string nm, input logic [31:0] e,
            input logic [31:0] m);
        @(posedge i_core_clk);
        notes.push_back('{nm, e & m, m});
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_core_clk);
        bus.rd <= 1'b0;
    endtask

    // reference search: try each bit from the top, keep it while input is above
    function automatic logic [9:0] sar_expect(input logic [9:0] v);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 9; i >= 0; i--) begin
            r[i] = 1'b1;
            r[i] = v > r;
        end
        return r;
    endfunction

    // one conversion: start, check busy mid-run, wait for the end, read back
    task automatic conv(input bit ext, input bit masked, input logic [9:0] v,
            input logic [2:0] ch, input int lo);
        int cnt;
        logic [31:0] c;
        vin <= v;
        c = 32'h4 | {25'h0, ch, 4'h0} | (ext ? 32'h2 : 32'h1);
        bus_write(sadc_pkg::OFF_CTRL, c);
        if (ext) begin
            u_front.pulse(lo * MC, (lo + 1) * MC);
        end
        repeat (5 * MC) @(posedge i_core_clk);
        bus_read(sadc_pkg::OFF_CTRL, "busy", (c & 32'h76) | 32'h101, 32'h177);
        // channel must stand at the value written before the start
        check("channel", {29'h0, ch}, {29'h0, ana.channel});
        cnt = 5 * MC + 2;
        if (masked) begin
            repeat (52 * MC) @(posedge i_core_clk);
            check("irq masked", 32'h0, {31'h0, irq});
        end else begin
            while (irq !== 1'b1 && cnt < 60 * MC) begin
                @(posedge i_core_clk);
                cnt++;
            end
            if (!ext) begin
                check("done time", 32'h1, {31'h0, cnt > 50 * MC && cnt <= 51 * MC + 3});
            end
        end
        bus_read(sadc_pkg::OFF_STATUS, "done", 32'h1, 32'h1);
        bus_read(sadc_pkg::OFF_STATUS, "done cleared", 32'h0, 32'h1);
        bus_read(sadc_pkg::OFF_RESULT, "result", {22'h0, sar_expect(v)}, 32'h3FF);
        bus_read(sadc_pkg::OFF_CTRL, "idle", 32'h0, 32'h101);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h19a7));
        repeat (16) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 20; a += 4) begin
            bus_read(8'(a), "reset read", 32'h0, 32'hFFFFFFFF);
        end
        bus_write(sadc_pkg::OFF_CTRL, 32'h73);
        u_front.pulse(MC, MC);
        repeat (12 * MC) @(posedge i_core_clk);
        bus_read(sadc_pkg::OFF_CTRL, "disabled", 32'h0, 32'hFFFFFFFF);
        bus_write(sadc_pkg::OFF_CTRL, 32'h4);
        u_front.pulse(MC, 2 * MC);
        repeat (12 * MC) @(posedge i_core_clk);
        bus_read(sadc_pkg::OFF_CTRL, "no pin start", 32'h0, 32'h101);
        conv(1'b0, 1'b1, 10'h155, 3'h2, 1);
        bus_write(sadc_pkg::OFF_MASK, 32'h1);
        for (int k = 0; k < 6; k++) begin
            conv(k > 3, 1'b0, k == 0 ? 10'h3FF : k == 1 ? 10'h001 : 10'($urandom),
                3'($urandom), k - 3);
        end
        wrap_up();
    end
endmodule
